// >>> rtl/sensor_i2c_pkg.sv
// shared constants for the sensor two-wire register access block
package sensor_i2c_pkg;
  localparam logic [6:0] TARGET_ADDR = 7'h1A;
  localparam logic [15:0] ADDR_BLK_HIGH = 16'h0008;
  localparam logic [15:0] ADDR_BLK_LOW = 16'h0009;
  localparam logic [15:0] ADDR_STANDBY = 16'h0100;
  localparam logic [15:0] ADDR_SCAN = 16'h0101;
  localparam logic [8:0] BLK_OFFSET_RST = 9'h040;
  localparam logic STANDBY_RST = 1'b0;
  localparam logic FLIP_RST = 1'b0;
  localparam int BLK_HIGH_BIT = 0;
  localparam int STANDBY_BIT = 0;
  localparam int FLIP_BIT = 1;
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [1:0] DATA_BYTE = 2'h2;
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_RX, ST_RX_ACK, ST_TX, ST_TX_ACK
  } link_state_t;
endpackage

// >>> rtl/sensor_i2c_register_access.sv
// two-wire target giving an external master access to the sensor control registers
// Summary of operation
// - index pointer selects every accessed register
// - write-direction register address loads the pointer
// - pointer advances at each data byte acknowledge
// - acknowledge read address, then drive indexed data
// - current-location read needs no address phase
// - master acknowledge advances pointer, sends next byte
// - acknowledge write data and advance address together
// - nine-bit black offset, reset 040h, immediate
// - standby select bit, zero means standby
// - scan direction bit, applied at frame boundary
// - these functions respond only over two-wire access
// - target address 0011010, direction bit follows
// - 16-bit register address, bytes sent MSB first
`timescale 1ns/10ps
module sensor_i2c_register_access (
  // system side
  input wire logic clk,
  input wire logic arst_n,
  input wire logic frameStart,
  // serial link
  input wire logic linkClk,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  // control outputs
  output logic [8:0] blackOffset,
  output logic normalMode,
  output logic verticalFlip
);
  // link domain state
  logic sclS1, sclS2, sclS3, sdaS1, sdaS2, sdaS3;
  sensor_i2c_pkg::link_state_t state_q;
  logic [3:0] bitCnt_q;
  logic [7:0] shift_q;
  logic [1:0] byteIdx_q;
  logic isRead_q, ackOn_q, sdaOe_q, sdaOut_q;
  logic [15:0] ptr_q;
  logic [7:0] ptrHigh_q;
  logic fetch_q;
  logic [15:0] reqAddr_q;
  logic [7:0] reqData_q;
  logic reqWe_q, reqTog_q;
  logic ackS1, ackS2, ackS3;
  logic [7:0] rdHold_q;
  logic sclRise, sclFall, startSeen, stopSeen;
  // system domain state
  logic reqS1, reqS2, reqS3, ackTog_q;
  logic [7:0] rdData_q;
  logic [7:0] blkLow_q;
  logic blkHigh_q, standby_q, flipPend_q, flipAct_q;
  logic frS1, frS2, frS3;
  logic reqEdge, frameEdge;

  // the oversampling link clock sees scl and sda only through two flops
  always_ff @(posedge linkClk or negedge arst_n) begin
    if (!arst_n) begin
      sclS1 <= 1'b1;
      sclS2 <= 1'b1;
      sclS3 <= 1'b1;
      sdaS1 <= 1'b1;
      sdaS2 <= 1'b1;
      sdaS3 <= 1'b1;
    end else begin
      sclS1 <= sclIn;
      sclS2 <= sclS1;
      sclS3 <= sclS2;
      sdaS1 <= sdaIn;
      sdaS2 <= sdaS1;
      sdaS3 <= sdaS2;
    end
  end

  assign sclRise = sclS2 & ~sclS3;
  assign sclFall = ~sclS2 & sclS3;
  assign startSeen = sclS2 & sclS3 & sdaS3 & ~sdaS2;
  assign stopSeen = sclS2 & sclS3 & ~sdaS3 & sdaS2;

  // protocol engine; no clock stretching, so a fetch must beat half an scl period
  always_ff @(posedge linkClk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= sensor_i2c_pkg::ST_IDLE;
      bitCnt_q <= 4'h0;
      shift_q <= 8'h00;
      byteIdx_q <= 2'h0;
      isRead_q <= 1'b0;
      ackOn_q <= 1'b0;
      sdaOe_q <= 1'b0;
      ptr_q <= 16'h0000;
      ptrHigh_q <= 8'h00;
      fetch_q <= 1'b0;
    end else begin
      fetch_q <= 1'b0;
      if (startSeen) begin
        state_q <= sensor_i2c_pkg::ST_ADDR;
        bitCnt_q <= 4'h0;
        byteIdx_q <= 2'h0;
        sdaOe_q <= 1'b0;
      end else if (stopSeen) begin
        state_q <= sensor_i2c_pkg::ST_IDLE;
        sdaOe_q <= 1'b0;
      end else begin
        unique case (state_q)
          sensor_i2c_pkg::ST_IDLE: begin
            sdaOe_q <= 1'b0;
          end
          sensor_i2c_pkg::ST_ADDR: begin
            if (sclRise) begin
              shift_q <= {shift_q[6:0], sdaS2};
              bitCnt_q <= bitCnt_q + 4'h1;
              if (bitCnt_q == sensor_i2c_pkg::LAST_BIT) begin
                if (shift_q[6:0] == sensor_i2c_pkg::TARGET_ADDR) begin
                  isRead_q <= sdaS2;
                  ackOn_q <= 1'b0;
                  state_q <= sensor_i2c_pkg::ST_ADDR_ACK;
                  fetch_q <= sdaS2;
                end else begin
                  state_q <= sensor_i2c_pkg::ST_IDLE;
                end
              end
            end
          end
          sensor_i2c_pkg::ST_ADDR_ACK: begin
            if (sclFall && !ackOn_q) begin
              ackOn_q <= 1'b1;
              sdaOe_q <= 1'b1;
            end else if (sclFall) begin
              bitCnt_q <= 4'h0;
              if (isRead_q) begin
                sdaOe_q <= ~rdHold_q[7];
                shift_q <= {rdHold_q[6:0], 1'b0};
                state_q <= sensor_i2c_pkg::ST_TX;
              end else begin
                sdaOe_q <= 1'b0;
                state_q <= sensor_i2c_pkg::ST_RX;
              end
            end
          end
          sensor_i2c_pkg::ST_RX: begin
            if (sclRise) begin
              shift_q <= {shift_q[6:0], sdaS2};
              bitCnt_q <= bitCnt_q + 4'h1;
              if (bitCnt_q == sensor_i2c_pkg::LAST_BIT) begin
                ackOn_q <= 1'b0;
                state_q <= sensor_i2c_pkg::ST_RX_ACK;
              end
            end
          end
          sensor_i2c_pkg::ST_RX_ACK: begin
            if (sclFall && !ackOn_q) begin
              ackOn_q <= 1'b1;
              sdaOe_q <= 1'b1;
              if (byteIdx_q == 2'h0) begin
                ptrHigh_q <= shift_q;
              end else if (byteIdx_q == 2'h1) begin
                ptr_q <= {ptrHigh_q, shift_q};
              end else begin
                ptr_q <= ptr_q + 16'h0001;
              end
              if (byteIdx_q != sensor_i2c_pkg::DATA_BYTE) begin
                byteIdx_q <= byteIdx_q + 2'h1;
              end
            end else if (sclFall) begin
              sdaOe_q <= 1'b0;
              bitCnt_q <= 4'h0;
              state_q <= sensor_i2c_pkg::ST_RX;
            end
          end
          sensor_i2c_pkg::ST_TX: begin
            if (sclRise) begin
              bitCnt_q <= bitCnt_q + 4'h1;
              if (bitCnt_q == sensor_i2c_pkg::LAST_BIT) begin
                ackOn_q <= 1'b0;
                state_q <= sensor_i2c_pkg::ST_TX_ACK;
              end
            end else if (sclFall) begin
              sdaOe_q <= ~shift_q[7];
              shift_q <= {shift_q[6:0], 1'b0};
            end
          end
          sensor_i2c_pkg::ST_TX_ACK: begin
            if (sclFall && !ackOn_q) begin
              sdaOe_q <= 1'b0;
            end else if (sclRise) begin
              ptr_q <= ptr_q + 16'h0001;
              fetch_q <= 1'b1;
              if (sdaS2) begin
                state_q <= sensor_i2c_pkg::ST_IDLE;
              end else begin
                ackOn_q <= 1'b1;
              end
            end else if (sclFall) begin
              bitCnt_q <= 4'h0;
              sdaOe_q <= ~rdHold_q[7];
              shift_q <= {rdHold_q[6:0], 1'b0};
              state_q <= sensor_i2c_pkg::ST_TX;
            end
          end
        endcase
      end
    end
  end

  // requests to the register file; bus words settle with the toggle, read two flops later
  always_ff @(posedge linkClk or negedge arst_n) begin
    if (!arst_n) begin
      reqAddr_q <= 16'h0000;
      reqData_q <= 8'h00;
      reqWe_q <= 1'b0;
      reqTog_q <= 1'b0;
    end else if (state_q == sensor_i2c_pkg::ST_RX_ACK && sclFall && !ackOn_q &&
                 byteIdx_q == sensor_i2c_pkg::DATA_BYTE && !startSeen && !stopSeen) begin
      reqAddr_q <= ptr_q;
      reqData_q <= shift_q;
      reqWe_q <= 1'b1;
      reqTog_q <= ~reqTog_q;
    end else if (fetch_q) begin
      reqAddr_q <= ptr_q;
      reqWe_q <= 1'b0;
      reqTog_q <= ~reqTog_q;
    end
  end

  // read data comes back with the answer toggle
  always_ff @(posedge linkClk or negedge arst_n) begin
    if (!arst_n) begin
      ackS1 <= 1'b0;
      ackS2 <= 1'b0;
      ackS3 <= 1'b0;
      rdHold_q <= 8'h00;
    end else begin
      ackS1 <= ackTog_q;
      ackS2 <= ackS1;
      ackS3 <= ackS2;
      if (ackS2 != ackS3) begin
        rdHold_q <= rdData_q;
      end
    end
  end

  // sda is open drain: only ever pulled low
  always_ff @(posedge linkClk or negedge arst_n) begin
    if (!arst_n) begin
      sdaOut_q <= 1'b0;
    end else begin
      sdaOut_q <= 1'b0;
    end
  end

  assign sdaOut = sdaOut_q;
  assign sdaOe = sdaOe_q;

  // system clock side of the request handshake
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reqS1 <= 1'b0;
      reqS2 <= 1'b0;
      reqS3 <= 1'b0;
      frS1 <= 1'b0;
      frS2 <= 1'b0;
      frS3 <= 1'b0;
    end else begin
      reqS1 <= reqTog_q;
      reqS2 <= reqS1;
      reqS3 <= reqS2;
      frS1 <= frameStart;
      frS2 <= frS1;
      frS3 <= frS2;
    end
  end

  assign reqEdge = reqS2 != reqS3;
  assign frameEdge = frS2 & ~frS3;

  // register file; unused bits are never stored so they read back as zero
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      blkHigh_q <= sensor_i2c_pkg::BLK_OFFSET_RST[8];
      blkLow_q <= sensor_i2c_pkg::BLK_OFFSET_RST[7:0];
      standby_q <= sensor_i2c_pkg::STANDBY_RST;
      flipPend_q <= sensor_i2c_pkg::FLIP_RST;
    end else if (reqEdge && reqWe_q) begin
      unique case (reqAddr_q)
        sensor_i2c_pkg::ADDR_BLK_HIGH:
          blkHigh_q <= reqData_q[sensor_i2c_pkg::BLK_HIGH_BIT];
        sensor_i2c_pkg::ADDR_BLK_LOW: blkLow_q <= reqData_q;
        sensor_i2c_pkg::ADDR_STANDBY:
          standby_q <= reqData_q[sensor_i2c_pkg::STANDBY_BIT];
        sensor_i2c_pkg::ADDR_SCAN: flipPend_q <= reqData_q[sensor_i2c_pkg::FLIP_BIT];
        default: ;
      endcase
    end
  end

  // readback and answer toggle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdData_q <= 8'h00;
      ackTog_q <= 1'b0;
    end else if (reqEdge) begin
      ackTog_q <= ~ackTog_q;
      unique case (reqAddr_q)
        sensor_i2c_pkg::ADDR_BLK_HIGH: rdData_q <= {7'h00, blkHigh_q};
        sensor_i2c_pkg::ADDR_BLK_LOW: rdData_q <= blkLow_q;
        sensor_i2c_pkg::ADDR_STANDBY: rdData_q <= {7'h00, standby_q};
        sensor_i2c_pkg::ADDR_SCAN: rdData_q <= {6'h00, flipPend_q, 1'b0};
        default: rdData_q <= 8'h00;
      endcase
    end
  end

  // scan direction changes only between frames to avoid a torn image
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      flipAct_q <= sensor_i2c_pkg::FLIP_RST;
    end else if (frameEdge) begin
      flipAct_q <= flipPend_q;
    end
  end

  assign blackOffset = {blkHigh_q, blkLow_q};
  assign normalMode = standby_q;
  assign verticalFlip = flipAct_q;

  chk_addr_reject: assert property (@(posedge linkClk) disable iff (!arst_n)
    state_q == sensor_i2c_pkg::ST_ADDR && sclRise && !startSeen && !stopSeen &&
    bitCnt_q == 4'h7 && shift_q[6:0] != 7'h1A |=> state_q == sensor_i2c_pkg::ST_IDLE)
    else $error("foreign target address not ignored");
  chk_ptr_load: assert property (@(posedge linkClk) disable iff (!arst_n)
    state_q == sensor_i2c_pkg::ST_RX_ACK && sclFall && !ackOn_q && byteIdx_q == 2'h1 &&
    !startSeen && !stopSeen |=> ptr_q[7:0] == $past(shift_q) && ptr_q[15:8] == $past(ptrHigh_q))
    else $error("pointer not loaded from register address");
  chk_write_advance: assert property (@(posedge linkClk) disable iff (!arst_n)
    state_q == sensor_i2c_pkg::ST_RX_ACK && sclFall && !ackOn_q && byteIdx_q == 2'h2 &&
    !startSeen && !stopSeen |=> ptr_q == $past(ptr_q) + 16'h0001 && reqWe_q && sdaOe_q)
    else $error("write byte not acknowledged and advanced");
  chk_read_advance: assert property (@(posedge linkClk) disable iff (!arst_n)
    state_q == sensor_i2c_pkg::ST_TX_ACK && sclRise && !startSeen && !stopSeen
    |=> ptr_q == $past(ptr_q) + 16'h0001 ##1 reqAddr_q == $past(ptr_q) && !reqWe_q)
    else $error("read pointer not advanced and fetched");
  chk_addr_ack: assert property (@(posedge linkClk) disable iff (!arst_n)
    state_q == sensor_i2c_pkg::ST_ADDR_ACK && sclFall && !ackOn_q && !startSeen && !stopSeen
    |=> sdaOe_q && ackOn_q)
    else $error("target address not acknowledged");
  chk_nack_end: assert property (@(posedge linkClk) disable iff (!arst_n)
    state_q == sensor_i2c_pkg::ST_TX_ACK && sclRise && sdaS2 && !startSeen && !stopSeen
    |=> state_q == sensor_i2c_pkg::ST_IDLE ##1 !sdaOe_q)
    else $error("read not ended on master nack");
  chk_blk_write: assert property (@(posedge clk) disable iff (!arst_n)
    reqEdge && reqWe_q && reqAddr_q == 16'h0009 |=> blkLow_q == $past(reqData_q))
    else $error("black offset write not immediate");
  chk_flip_hold: assert property (@(posedge clk) disable iff (!arst_n)
    !frameEdge |=> flipAct_q == $past(flipAct_q))
    else $error("scan direction changed outside frame boundary");
  chk_reserved_zero: assert property (@(posedge clk) disable iff (!arst_n)
    reqEdge && (reqAddr_q == 16'h0100 || reqAddr_q == 16'h0008) |=> rdData_q[7:1] == 7'h00)
    else $error("reserved bits read as nonzero");
endmodule

// >>> dv/i2c_master_model.sv
// behavioural two-wire bus master for the sensor link
`timescale 1ns/10ps
module i2c_master_model #(
  parameter int HALF = 100,
  parameter int LEAD = 25
) (
  // system side
  input wire logic clk,
  // bus lines
  input wire logic sdaWire,
  output logic sclOut,
  output logic sdaLow,
  // received byte
  output logic rdStrobe,
  output logic [7:0] rdByte
);
  initial begin
    sclOut = 1'b1;
    sdaLow = 1'b0;
    rdStrobe = 1'b0;
    rdByte = 8'h00;
  end

  always @(posedge clk) begin
    if (rdStrobe) begin
      rdStrobe <= 1'b0;
    end
  end

  task automatic waitCyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // same path serves idle start and repeated start after a byte
  task automatic startCond();
    waitCyc(LEAD);
    sdaLow <= 1'b0;
    waitCyc(HALF);
    sclOut <= 1'b1;
    waitCyc(HALF);
    sdaLow <= 1'b1;
    waitCyc(HALF);
    sclOut <= 1'b0;
  endtask

  task automatic stopCond();
    waitCyc(LEAD);
    sdaLow <= 1'b1;
    waitCyc(HALF);
    sclOut <= 1'b1;
    waitCyc(HALF);
    sdaLow <= 1'b0;
    waitCyc(HALF);
  endtask

  // sda moves well after the scl fall so no false start or stop is seen
  task automatic xferBit(input logic b, output logic s);
    waitCyc(LEAD);
    sdaLow <= ~b;
    waitCyc(HALF);
    sclOut <= 1'b1;
    waitCyc(HALF);
    s = sdaWire;
    sclOut <= 1'b0;
  endtask

  task automatic sendByte(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      xferBit(d[i], ack);
    end
    xferBit(1'b1, ack);
  endtask

  task automatic recvByte(input logic more, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      xferBit(1'b1, s);
      d[i] = s;
    end
    rdByte <= d;
    rdStrobe <= 1'b1;
    xferBit(~more, s);
  endtask
endmodule

// >>> dv/tb_sensor_i2c_register_access.sv
// self-checking bench for the sensor two-wire register access block
`timescale 1ns/10ps
module tb_sensor_i2c_register_access;
  logic clk;
  logic linkClk;
  logic arst_n;
  logic frameStart;
  logic sclOut;
  logic sdaLow;
  logic sdaWire;
  logic sdaOut;
  logic sdaOe;
  logic [8:0] blackOffset;
  logic normalMode;
  logic verticalFlip;
  logic rdStrobe;
  logic [7:0] rdByte;
  logic [7:0] rnd;
  logic [7:0] expQ[$];
  int num_errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  int seed = 32'h09BB4855;

  // open drain with pull-up: low while either side pulls
  assign sdaWire = !(sdaLow || (sdaOe && !sdaOut));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    linkClk = 1'b0;
    #1.7;
    forever #3 linkClk = ~linkClk;
  end

  sensor_i2c_register_access i_dut (
    .clk(clk),
    .arst_n(arst_n),
    .frameStart(frameStart),
    .linkClk(linkClk),
    .sclIn(sclOut),
    .sdaIn(sdaWire),
    .sdaOut(sdaOut),
    .sdaOe(sdaOe),
    .blackOffset(blackOffset),
    .normalMode(normalMode),
    .verticalFlip(verticalFlip)
  );

  i2c_master_model i_master (
    .clk(clk),
    .sdaWire(sdaWire),
    .sclOut(sclOut),
    .sdaLow(sdaLow),
    .rdStrobe(rdStrobe),
    .rdByte(rdByte)
  );

  task automatic cmpVal(input string what, input logic [8:0] exp, input logic [8:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic putByte(input logic [7:0] b, input logic expAck);
    logic ack;
    i_master.sendByte(b, ack);
    cmpVal("ack", {8'h00, expAck}, {8'h00, ack});
  endtask

  task automatic setPtr(input logic [15:0] a);
    i_master.startCond();
    putByte({sensor_i2c_pkg::TARGET_ADDR, 1'b0}, 1'b0);
    putByte(a[15:8], 1'b0);
    putByte(a[7:0], 1'b0);
  endtask

  task automatic writeRegs(input logic [15:0] a, input logic [7:0] d[$]);
    setPtr(a);
    foreach (d[i]) begin
      putByte(d[i], 1'b0);
    end
    i_master.stopCond();
  endtask

  // without an address phase the read starts at the current index
  task automatic readRegs(input logic useAddr, input logic [15:0] a, input logic [7:0] e[$]);
    logic [7:0] d;
    if (useAddr) begin
      setPtr(a);
    end
    i_master.startCond();
    putByte({sensor_i2c_pkg::TARGET_ADDR, 1'b1}, 1'b0);
    foreach (e[i]) begin
      expQ.push_back(e[i]);
      i_master.recvByte(i < e.size() - 1, d);
    end
    i_master.stopCond();
  endtask

  task automatic checkOuts(input logic [8:0] blk, input logic nm, input logic fl);
    cmpVal("blackOffset", blk, blackOffset);
    cmpVal("normalMode", {8'h00, nm}, {8'h00, normalMode});
    cmpVal("verticalFlip", {8'h00, fl}, {8'h00, verticalFlip});
  endtask

  always @(posedge clk) begin
    if (rdStrobe === 1'b1 && expQ.size() > 0) begin
      cmpVal("readByte", {1'b0, expQ.pop_front()}, {1'b0, rdByte});
    end
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      num_errors++;
      results();
    end
  end

  initial begin
    arst_n = 1'b0;
    frameStart = 1'b0;
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    repeat (5) @(posedge clk);
    checkOuts(9'h040, 1'b0, 1'b0);
    $display("test reset values done");
    rnd = 8'($random(seed));
    writeRegs(16'h0008, '{8'h01, rnd});
    checkOuts({1'b1, rnd}, 1'b0, 1'b0);
    $display("test burst write done");
    // unused bits kept at zero; the master side must never set them
    writeRegs(16'h0100, '{8'h01, 8'h02});
    checkOuts({1'b1, rnd}, 1'b1, 1'b0);
    frameStart <= 1'b1;
    repeat (4) @(posedge clk);
    frameStart <= 1'b0;
    repeat (12) @(posedge clk);
    checkOuts({1'b1, rnd}, 1'b1, 1'b1);
    $display("test mode write done");
    // burst runs on into unmapped space, which reads as zero
    readRegs(1'b1, 16'h0008, '{8'h01, rnd, 8'h00, 8'h00});
    readRegs(1'b1, 16'h0100, '{8'h01, 8'h02});
    readRegs(1'b1, 16'h0008, '{8'h01});
    readRegs(1'b0, 16'h0000, '{rnd});
    $display("test reads done");
    i_master.startCond();
    putByte({7'h1B, 1'b0}, 1'b1);
    i_master.stopCond();
    readRegs(1'b0, 16'h0000, '{8'h00});
    $display("test foreign address done");
    cmpVal("readsLeft", 9'h000, 9'(expQ.size()));
    results();
  end
endmodule
